// File: rtl/sar_adc_scan_control.sv
// Scan sequencer and AXI4-Lite register slave of the converter control
//
// Summary of operation
// RL1 - Loop bit 0: single pass over enabled channels, or repeat scans forever.
// RL2 - Software keeps loop bit clear whenever trigger mode is selected.
// RL3 - Clock source bit 1: 0 low-speed, 1 high-speed oscillator; resets to 1.
// RL4 - Software selects high-speed clock whenever touch conversion is used.
// RL5 - Touch mode bit 2 converts marked channels with touch support.
// RL6 - Divider bits 5:4: 00 by one, 01 by two, 10 by four; 11 prohibited.
// RL7 - Software keeps divided clock under 4MHz or 32.768kHz.
// RL8 - Conversion time stretches in proportion to the divide ratio.
// RL9 - Suggested divider codes: 16MHz 10, 8MHz 01, 4MHz 00.
// RL10 - Software leaves the divider alone during conversion.
// RL11 - Run bit 0 of run control: write 1 starts, 0 stops; resets 0.
// RL12 - Single scan clears run after highest enabled channel converts.
// RL13 - Trigger mode ignores software run writes; trigger sets, completion clears.
// RL14 - Software never starts with every channel enable bit clear.
// RL15 - Channel enable bits 11:0 include channels in the scan; reset 0.
// RL16 - Enabled channels convert in ascending channel-number order.
// RL17 - Touch channel bits 11:0 enable touch mode per channel; reset 0.
// RL18 - Touch bit without enable bit never causes conversion.
// RL19 - Each converted channel's 12-bit result lands in its result register.
// RL20 - Triggers arriving while run is high are ignored.
// RL21 - Start with no channels enabled: no completion event, run stays 1.
// RL22 - One-cycle completion pulse when a single scan finishes.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns
module sar_adc_scan_control (
	input  wire logic                               sys_clk,
	input  wire logic                               rst_b,
	input  wire logic [adc_scan_pkg::AW-1:0]        s_axi_awaddr,
	input  wire logic                               s_axi_awvalid,
	output logic                                    s_axi_awready,
	input  wire logic [31:0]                        s_axi_wdata,
	input  wire logic [3:0]                         s_axi_wstrb,
	input  wire logic                               s_axi_wvalid,
	output logic                                    s_axi_wready,
	output logic [1:0]                              s_axi_bresp,
	output logic                                    s_axi_bvalid,
	input  wire logic                               s_axi_bready,
	input  wire logic [adc_scan_pkg::AW-1:0]        s_axi_araddr,
	input  wire logic                               s_axi_arvalid,
	output logic                                    s_axi_arready,
	output logic [31:0]                             s_axi_rdata,
	output logic [1:0]                              s_axi_rresp,
	output logic                                    s_axi_rvalid,
	input  wire logic                               s_axi_rready,
	input  wire logic                               trigger_event,
	output adc_scan_pkg::conv_req_s                 conv_req,
	input  wire logic                               conv_done,
	input  wire logic [adc_scan_pkg::RES_W-1:0]     conv_result,
	output logic                                    scan_complete
);
	import adc_scan_pkg::*;

	// Address decode helper used by both channels
	function automatic logic [3:0] reg_sel(input logic [AW-1:0] a);
		logic [IDX_W-1:0] w;
		w = a[AW-1:2];
		if (w == OFF_CTRL0) reg_sel = 4'h1;
		else if (w == OFF_RUN) reg_sel = 4'h6;
		else if (w == OFF_CHEN) reg_sel = 4'h2;
		else if (w == OFF_TOUCH) reg_sel = 4'h3;
		else if (w == OFF_TRIG) reg_sel = 4'h4;
		// Results sit on every second index, one per channel
		else if (w >= OFF_RES_BASE && w <= OFF_RES_LAST && !w[0])
			reg_sel = 4'h5;
		else reg_sel = 4'h0;
	endfunction : reg_sel

	// First set bit at or above a position, ascending
	function automatic logic [4:0] next_ch(input logic [NUM_CH-1:0] m,
		input logic [4:0] from);
		next_ch = 5'h1f;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (m[i] && 5'(i) >= from) next_ch = 5'(i);
		end
	endfunction : next_ch

	logic [7:0]        ctrl0_q;
	logic              run_q;
	logic [NUM_CH-1:0] chen_q;
	logic [NUM_CH-1:0] touch_q;
	logic              trig_mode_q;
	logic [AW-1:0]     awaddr_q;
	logic              aw_held_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;
	logic              w_held_q;
	logic              rd_pend_q;
	logic [3:0]        rd_sel_q;
	logic [7:0]        rd_lane_q;
	scan_state_e       state_q;
	logic [3:0]        ch_q;
	logic [9:0]        wait_q;
	logic              done_seen_q;
	logic [RES_W-1:0]  res_hold_q;
	logic              res_we;
	logic [RES_W-1:0]  res_rd;

	// Each register owns one aligned 32-bit word, lane 0 upwards
	wire        wr_fire    = aw_held_q && w_held_q && !s_axi_bvalid;
	wire [3:0]  wr_sel     = reg_sel(awaddr_q);
	wire        wr_ctrl0   = wr_fire && wr_sel == 4'h1 && wstrb_q[0];
	wire        wr_run     = wr_fire && wr_sel == 4'h6 && wstrb_q[0];
	wire        wr_chen    = wr_fire && wr_sel == 4'h2;
	wire        wr_touch   = wr_fire && wr_sel == 4'h3;
	wire        wr_trig    = wr_fire && wr_sel == 4'h4 && wstrb_q[0];
	wire        loop_mode  = ctrl0_q[LOOP_BIT];
	wire        touch_mode = ctrl0_q[TOUCH_BIT];
	wire [1:0]  divider    = ctrl0_q[DIV_LSB +: 2];
	// Touch channel only counts where it is also enabled
	wire [NUM_CH-1:0] active_mask = touch_mode ? (chen_q & touch_q)
		: (chen_q & ~touch_q); // RL5 RL18
	wire [4:0]  first_ch   = next_ch(active_mask, 5'h00); // RL16
	wire [4:0]  after_ch   = next_ch(active_mask, 5'({1'b0, ch_q} + 5'h01));
	wire        sw_start   = wr_run && !trig_mode_q
		&& wdata_q[RUN_BIT] == 1'b1 && !run_q; // RL11 RL13
	wire        sw_stop    = wr_run && !trig_mode_q
		&& wdata_q[RUN_BIT] == 1'b0; // RL11 RL13
	wire        trig_start = trig_mode_q && trigger_event && !run_q; // RL20
	// Slower clocks stretch the conversion wait in proportion
	wire [9:0]  conv_len   = (divider == DIV_4) ? {BASE_CYCLES, 2'b00}
		: (divider == DIV_2) ? {1'b0, BASE_CYCLES, 1'b0}
		: {2'b00, BASE_CYCLES}; // RL6 RL8
	// Core may finish before the wait; its pulse is held until then
	wire        conv_fin   = state_q == ST_CONV && wait_q == '0
		&& (conv_done || done_seen_q);
	wire [RES_W-1:0] res_data = conv_done ? conv_result : res_hold_q;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= '0;
			wstrb_q   <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			s_axi_awready <= !(aw_held_q || (s_axi_awvalid && s_axi_awready));
			s_axi_wready  <= !(w_held_q || (s_axi_wvalid && s_axi_wready));
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_sel == 4'h0 || wr_sel == 4'h5)
					? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Software registers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl0_q     <= CTRL0_RESET; // RL3 RL6
			chen_q      <= '0; // RL15
			touch_q     <= '0; // RL17
			trig_mode_q <= 1'b0;
		end else begin
			if (wr_ctrl0) begin
				// Prohibited divider code is refused, previous kept
				ctrl0_q <= {2'b00,
					(wdata_q[DIV_LSB +: 2] == 2'b11) ? divider
						: wdata_q[DIV_LSB +: 2],
					1'b0, wdata_q[TOUCH_BIT], wdata_q[CKSRC_BIT],
					wdata_q[LOOP_BIT]}; // RL1 RL3 RL5 RL6
			end
			if (wr_chen) begin
				chen_q <= wdata_q[NUM_CH-1:0]; // RL15
			end
			if (wr_touch) begin
				touch_q <= wdata_q[NUM_CH-1:0]; // RL17
			end
			if (wr_trig) begin
				trig_mode_q <= wdata_q[TRIG_BIT];
			end
		end
	end

	// Scan sequencer
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q       <= ST_IDLE;
			run_q         <= 1'b0;
			ch_q          <= '0;
			wait_q        <= '0;
			done_seen_q   <= 1'b0;
			res_hold_q    <= '0;
			scan_complete <= 1'b0;
			conv_req      <= '0;
		end else begin
			scan_complete  <= 1'b0;
			conv_req.start <= 1'b0;
			if (sw_stop) begin
				run_q   <= 1'b0; // RL11
				state_q <= ST_IDLE;
			end else begin
				unique case (state_q)
					ST_IDLE: begin
						if (sw_start || trig_start) begin
							run_q   <= 1'b1; // RL11 RL13
							state_q <= ST_PICK;
							ch_q    <= 4'h0;
						end
					end
					ST_PICK: begin
						// Nothing enabled: circuit never runs, run stays high
						if (first_ch[4] && ch_q == 4'h0) begin
							state_q <= ST_STUCK; // RL21
						end else begin
							ch_q    <= (ch_q == 4'h0) ? first_ch[3:0] : ch_q;
							state_q <= ST_CONV;
							wait_q  <= conv_len; // RL8
							done_seen_q <= 1'b0;
							conv_req.start   <= 1'b1;
							conv_req.channel <= (ch_q == 4'h0)
								? first_ch[3:0] : ch_q;
							conv_req.touch   <= touch_mode;
							conv_req.clk_sel <= ctrl0_q[CKSRC_BIT];
							conv_req.divider <= divider;
						end
					end
					ST_CONV: begin
						if (wait_q != '0) begin
							wait_q <= wait_q - 10'h001;
						end
						if (conv_done) begin
							done_seen_q <= 1'b1;
							res_hold_q  <= conv_result;
						end
						if (conv_fin) begin
							if (!after_ch[4]) begin
								ch_q    <= after_ch[3:0]; // RL16
								state_q <= ST_PICK;
							end else begin
								scan_complete <= 1'b1; // RL22
								if (loop_mode && !trig_mode_q) begin
									ch_q    <= 4'h0; // RL1
									state_q <= ST_PICK;
								end else begin
									run_q   <= 1'b0; // RL12 RL13
									state_q <= ST_IDLE;
								end
							end
						end
					end
					ST_STUCK: begin
						state_q <= ST_STUCK; // RL21
					end
				endcase
			end
		end
	end

	assign res_we = conv_fin; // RL19

	result_mem u_result_mem (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.wr_en   (res_we),
		.wr_addr (ch_q),
		.wr_data (res_data),
		.rd_addr (s_axi_araddr[RES_CH_LSB +: 4]),
		.rd_data (res_rd)
	);

	// Reads: result memory has one cycle latency, answered next cycle
	wire [3:0] ar_sel = reg_sel(s_axi_araddr);
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
			rd_pend_q     <= 1'b0;
			rd_sel_q      <= '0;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				rd_pend_q     <= 1'b1;
				rd_sel_q      <= ar_sel;
			end else if (rd_pend_q) begin
				rd_pend_q    <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= (rd_sel_q == 4'h0) ? RESP_SLVERR : RESP_OKAY;
				unique case (rd_sel_q)
					4'h1: s_axi_rdata <= {24'h000000, ctrl0_q};
					4'h6: s_axi_rdata <= {31'h00000000, run_q};
					4'h2: s_axi_rdata <= {20'h00000, chen_q};
					4'h3: s_axi_rdata <= {20'h00000, touch_q};
					4'h4: s_axi_rdata <= {31'h00000000, trig_mode_q};
					4'h5: s_axi_rdata <= {20'h00000, res_rd};
					default: s_axi_rdata <= '0;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	a_single_clears: assert property (@(posedge sys_clk) disable iff (!rst_b)
		scan_complete && !loop_mode |-> !run_q) // RL12
		else $error("run still set after single scan");
	a_trig_ignored: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL20
		run_q && trig_mode_q && !sw_stop |=> run_q || scan_complete)
		else $error("run dropped without completion");
	a_stuck_run: assert property (@(posedge sys_clk) disable iff (!rst_b)
		state_q == ST_STUCK |-> run_q && !scan_complete) // RL21
		else $error("empty scan changed run or completed");
	a_done_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
		scan_complete |=> !scan_complete) // RL22
		else $error("completion longer than one cycle");
	a_enabled_only: assert property (@(posedge sys_clk) disable iff (!rst_b)
		conv_req.start |-> active_mask[conv_req.channel]) // RL18
		else $error("disabled channel converted");
	a_no_bad_div: assert property (@(posedge sys_clk) disable iff (!rst_b)
		divider != 2'b11) // RL6
		else $error("prohibited divider stored");
	a_stretch_time: assert property (@(posedge sys_clk) disable iff (!rst_b) // RL8
		conv_req.start && divider == DIV_4 |-> wait_q == {BASE_CYCLES, 2'b00})
		else $error("conversion wait not stretched");
	a_sw_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
		sw_start && state_q == ST_IDLE |=> run_q) // RL11
		else $error("software start ignored");
	a_trig_sw: assert property (@(posedge sys_clk) disable iff (!rst_b)
		trig_mode_q && !run_q && !trigger_event |=> !run_q) // RL13
		else $error("run set without trigger");
	a_ascending: assert property (@(posedge sys_clk) disable iff (!rst_b)
		conv_fin && !after_ch[4] |=> ##1 conv_req.start
		&& (conv_req.channel > $past(ch_q, 2))) // RL16
		else $error("channel order broken");
	c_single: cover property (@(posedge sys_clk) scan_complete && !loop_mode);
	c_loop: cover property (@(posedge sys_clk) scan_complete && loop_mode);
	c_trig: cover property (@(posedge sys_clk) trig_start);
	c_stuck: cover property (@(posedge sys_clk) state_q == ST_STUCK);
endmodule : sar_adc_scan_control

// File: shared/adc_scan_pkg.sv
// Register map, field layout and shared types of the converter scan control
package adc_scan_pkg;
	localparam int                 NUM_CH        = 12;
	localparam int                 RES_W         = 12;
	localparam int                 IDX_W         = 16;
	localparam int                 AW            = IDX_W + 2;
	localparam int                 CLK_HZ        = 10_000_000;
	// Register indices; the byte address is four times the index
	localparam logic [IDX_W-1:0]   OFF_CTRL0     = 16'hf840;
	localparam logic [IDX_W-1:0]   OFF_RUN       = 16'hf841;
	localparam logic [IDX_W-1:0]   OFF_CHEN      = 16'hf842;
	localparam logic [IDX_W-1:0]   OFF_TOUCH     = 16'hf844;
	localparam logic [IDX_W-1:0]   OFF_TRIG      = 16'hf846;
	localparam logic [IDX_W-1:0]   OFF_RES_BASE  = 16'hf820;
	localparam logic [IDX_W-1:0]   OFF_RES_LAST  = 16'hf836;
	localparam int                 RES_CH_LSB    = 3;
	localparam logic [7:0]         CTRL0_RESET   = 8'h22;
	localparam int                 LOOP_BIT      = 0;
	localparam int                 CKSRC_BIT     = 1;
	localparam int                 TOUCH_BIT     = 2;
	localparam int                 DIV_LSB       = 4;
	localparam int                 RUN_BIT       = 0;
	localparam int                 TRIG_BIT      = 0;
	localparam logic [1:0]         DIV_1         = 2'h0;
	localparam logic [1:0]         DIV_2         = 2'h1;
	localparam logic [1:0]         DIV_4         = 2'h2;
	localparam logic [7:0]         BASE_CYCLES   = 8'h10;
	localparam logic [1:0]         RESP_OKAY     = 2'h0;
	localparam logic [1:0]         RESP_SLVERR   = 2'h2;

	typedef struct packed {
		logic        start;
		logic [3:0]  channel;
		logic        touch;
		logic        clk_sel;
		logic [1:0]  divider;
	} conv_req_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PICK = 2'b01,
		ST_CONV = 2'b10,
		ST_STUCK = 2'b11
	} scan_state_e;
endpackage : adc_scan_pkg

// File: rtl/result_mem.sv
// Per-channel result storage with registered read port
`timescale 1ns/1ns
module result_mem (
	input  wire logic                                sys_clk,
	input  wire logic                                rst_b,
	input  wire logic                                wr_en,
	input  wire logic [3:0]                          wr_addr,
	input  wire logic [adc_scan_pkg::RES_W-1:0]      wr_data,
	input  wire logic [3:0]                          rd_addr,
	output logic      [adc_scan_pkg::RES_W-1:0]      rd_data
);
	import adc_scan_pkg::*;
	logic [RES_W-1:0] mem_q [NUM_CH];

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_CH; i++) begin
				mem_q[i] <= '0;
			end
			rd_data <= '0;
		end else begin
			if (wr_en) begin
				mem_q[wr_addr] <= wr_data;
			end
			rd_data <= (rd_addr < 4'(NUM_CH)) ? mem_q[rd_addr] : '0;
		end
	end
endmodule : result_mem

// File: bench/conv_core_model.sv
// Behavioural converter core: answers every start after a set latency
`timescale 1ns/1ns
module conv_core_model (
	input  wire logic                           sys_clk,
	input  wire logic                           rst_b,
	input  adc_scan_pkg::conv_req_s             conv_req,
	input  wire logic [7:0]                     lat,
	output logic                                conv_done,
	output logic [adc_scan_pkg::RES_W-1:0]      conv_result
);
	import adc_scan_pkg::*;
	logic [7:0] cnt_q;
	logic [3:0] ch_q;
	logic       busy_q;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			busy_q <= 1'b0;
			cnt_q <= 8'h00;
			ch_q <= 4'h0;
			conv_done <= 1'b0;
			conv_result <= '0;
		end else begin
			conv_done <= 1'b0;
			// Stale data toggles so it never passes as a result
			conv_result <= ~conv_result;
			if (conv_req.start) begin
				busy_q <= 1'b1;
				cnt_q <= lat;
				ch_q <= conv_req.channel;
			end else if (busy_q && cnt_q == 8'h00) begin
				busy_q <= 1'b0;
				conv_done <= 1'b1;
				conv_result <= {ch_q, 8'ha5};
			end else if (busy_q) begin
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end
endmodule : conv_core_model

// File: bench/tb.sv
// Self-checking bench of the converter scan control
`timescale 1ns/1ns
module tb;
	import adc_scan_pkg::*;
	logic             sys_clk, rst_b, trigger_event, conv_done, scan_complete;
	logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic             s_axi_rvalid, s_axi_rready;
	logic [AW-1:0]    s_axi_awaddr, s_axi_araddr;
	logic [31:0]      s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]       s_axi_wstrb;
	logic [1:0]       s_axi_bresp, s_axi_rresp, rsp;
	logic [RES_W-1:0] conv_result;
	logic [7:0]       lat, c0;
	logic [11:0]      en, tch;
	logic             tm;
	conv_req_s        conv_req;
	conv_req_s        seen[$];
	int               miscompares, comparisons, cycles, scans, t1, t4;

	sar_adc_scan_control dut_u (.sys_clk, .rst_b, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.trigger_event, .conv_req, .conv_done, .conv_result, .scan_complete);
	conv_core_model core_u (.sys_clk, .rst_b, .conv_req, .lat, .conv_done,
		.conv_result);

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (rst_b && conv_req.start === 1'b1) seen.push_back(conv_req);
		if (rst_b && scan_complete === 1'b1) scans++;
		// Ceiling well above the longest scan sequence
		if (cycles > 60000) begin
			miscompares++;
			test_done();
		end
	end

	task automatic test_done();
		$display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done

	task automatic check(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : check

	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				rsp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask : wr

	task automatic rdt(input logic [AW-1:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				rd = s_axi_rdata;
				rsp = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask : rdt

	function automatic logic [AW-1:0] ra(logic [IDX_W-1:0] i);
		return {i, 2'b00};
	endfunction : ra

	function automatic logic [11:0] em(logic [7:0] c, logic [11:0] e,
		logic [11:0] t);
		return c[TOUCH_BIT] ? (e & t) : (e & ~t);
	endfunction : em

	// Stop goes first only when r is 0, start last only when r is 1; only the stop keeps setup from moving mid-conversion
	task automatic cfg(input logic [7:0] c, input logic r,
		input logic [11:0] e);
		if (!r) wr(ra(OFF_RUN), 32'h0);
		wr(ra(OFF_CHEN), {20'h0, e});
		wr(ra(OFF_CTRL0), {24'h0, c});
		if (r) wr(ra(OFF_RUN), 32'h1);
	endtask : cfg

	function automatic logic [7:0] ctl(logic [1:0] dv, logic t, logic ck,
		logic lp);
		return {2'h0, dv, 1'b0, t, ck, lp};
	endfunction : ctl

	task automatic wait_scan(input int n);
		while (scans < n) @(posedge sys_clk);
	endtask : wait_scan

	task automatic run_scan(input logic [7:0] c, input logic [11:0] e,
		input logic [11:0] t, output int el);
		int k;
		int t0;
		logic [11:0] m;
		k = 0;
		m = em(c, e, t);
		wr(ra(OFF_TOUCH), {20'h0, t});
		cfg(c, 1'b0, e);
		seen.delete();
		scans = 0;
		t0 = cycles;
		wr(ra(OFF_RUN), 32'h1);
		wait_scan(1);
		el = cycles - t0;
		repeat (5) @(posedge sys_clk);
		for (int i = 0; i < NUM_CH; i++) begin
			if (m[i]) begin
				check(k < seen.size() && seen[k].channel === 4'(i), "order");
				check(seen[k].touch === c[TOUCH_BIT], "touch flag");
				check({seen[k].clk_sel, seen[k].divider} === {c[1], c[5:4]},
					"clock setup");
				k++;
			end
		end
		check(seen.size() == k, "extra conversions");
		check(scans == 1, "completion pulse count");
		rdt(ra(OFF_RUN));
		check(rd[RUN_BIT] === 1'b0, "run left set");
		for (int i = 0; i < NUM_CH; i++) begin
			if (m[i]) begin
				rdt(ra(OFF_RES_BASE + 16'(2 * i)));
				check(rd[11:0] === {4'(i), 8'ha5}, "result");
			end
		end
	endtask : run_scan

	initial begin
		{rst_b, trigger_event, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		lat = 8'h01;
		{miscompares, comparisons, cycles, scans} = '0;
		void'($urandom(33314));
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		rdt(ra(OFF_CTRL0));
		check(rd[7:0] === CTRL0_RESET, "control reset");
		rdt(ra(OFF_RUN));
		check(rd[RUN_BIT] === 1'b0, "run reset");
		rdt(ra(OFF_CHEN));
		check(rd[11:0] === 12'h000, "enable reset");
		rdt(ra(OFF_TOUCH));
		check(rd[11:0] === 12'h000, "touch reset");
		rdt(18'h01000);
		check(rsp === RESP_SLVERR, "unmapped read");
		for (int n = 0; n < 4; n++) begin
			en = (n == 0) ? 12'hfff : (n == 1) ? 12'h800 : 12'($urandom());
			if (en == 12'h000) en = 12'h001;
			tch = 12'($urandom());
			tm = 1'($urandom());
			c0 = ctl(2'($urandom_range(2)), tm, tm | 1'($urandom()), 1'b0);
			if (em(c0, en, tch) == 12'h000) tch = ~tch;
			lat = (n == 3) ? 8'h28 : 8'h01;
			run_scan(c0, en, tch, t1);
		end
		lat = 8'h01;
		run_scan(ctl(DIV_1, 1'b0, 1'b1, 1'b0), 12'h004, 12'h0, t1);
		run_scan(ctl(DIV_4, 1'b0, 1'b1, 1'b0), 12'h004, 12'h0, t4);
		check(t4 > t1 + 40, "divider stretch");
		wr(ra(OFF_CTRL0), {24'h0, ctl(2'h3, 1'b0, 1'b1, 1'b0)});
		rdt(ra(OFF_CTRL0));
		check(rd[5:4] === DIV_4, "prohibited divider");
		scans = 0;
		cfg(ctl(DIV_1, 1'b0, 1'b1, 1'b1), 1'b1, 12'h081);
		wait_scan(2);
		rdt(ra(OFF_RUN));
		check(rd[RUN_BIT] === 1'b1, "loop ended");
		cfg(ctl(DIV_1, 1'b0, 1'b1, 1'b1), 1'b0, 12'h081);
		repeat (100) @(posedge sys_clk);
		seen.delete();
		repeat (200) @(posedge sys_clk);
		check(seen.size() == 0, "stop ignored");
		wr(ra(OFF_TRIG), 32'h1);
		seen.delete();
		scans = 0;
		cfg(ctl(DIV_1, 1'b0, 1'b1, 1'b0), 1'b1, 12'h003);
		repeat (50) @(posedge sys_clk);
		rdt(ra(OFF_RUN));
		check(rd[RUN_BIT] === 1'b0 && seen.size() == 0, "software run");
		@(posedge sys_clk) trigger_event <= 1'b1;
		@(posedge sys_clk) trigger_event <= 1'b0;
		rdt(ra(OFF_RUN));
		check(rd[RUN_BIT] === 1'b1, "trigger set run");
		@(posedge sys_clk) trigger_event <= 1'b1;
		@(posedge sys_clk) trigger_event <= 1'b0;
		wait_scan(1);
		repeat (300) @(posedge sys_clk);
		check(scans == 1 && seen.size() == 2, "retrigger");
		rdt(ra(OFF_RUN));
		check(rd[RUN_BIT] === 1'b0, "trigger run clear");
		wr(ra(OFF_TRIG), 32'h0);
		scans = 0;
		cfg(ctl(DIV_1, 1'b0, 1'b1, 1'b0), 1'b1, 12'h000);
		repeat (300) @(posedge sys_clk);
		rdt(ra(OFF_RUN));
		check(rd[RUN_BIT] === 1'b1 && scans == 0, "empty scan");
		cfg(ctl(DIV_1, 1'b0, 1'b1, 1'b0), 1'b0, 12'h000);
		test_done();
	end
endmodule : tb
